//--- sar_adc_params.svh
// Constants of the successive-approximation converter control block.
// Assumes a single 50 MHz system clock; included by the package and both converter modules.
`ifndef SAR_ADC_PARAMS_SVH
`define SAR_ADC_PARAMS_SVH

`define RESULT_WIDTH    8
`define CTRL_WIDTH      8
`define CTRL_IRQ_EN_BIT 7
`define CTRL_DONE_BIT   6
`define CTRL_TRIG_BIT   5
`define CTRL_POWER_BIT  4
`define CTRL_RESET      8'h40
`define RESULT_RESET    8'h00
`define SAR_FIRST_MASK  8'h80
`define SAR_LAST_MASK   8'h01
`define CONV_TIME_NS    70000
`define CLK_PERIOD_NS   20
`define CONV_CYCLES     (`CONV_TIME_NS / `CLK_PERIOD_NS)
`define BIT_CYCLES      (`CONV_CYCLES / `RESULT_WIDTH)

`endif

//--- sar_adc_pkg.sv
// Types shared by the converter control block and its approximation register.
// Assumes the constants header is on the include path.
`include "sar_adc_params.svh"

package sar_adc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b01,
    ST_CONVERT = 2'b10
  } conv_state_t;

  typedef struct packed {
    logic                     strobe;
    logic [`CTRL_WIDTH-1:0]   data;
  } ctrl_write_t;

  typedef struct packed {
    logic irq_en;
    logic power_on;
  } ctrl_bits_t;

  function automatic logic is_trigger(input ctrl_write_t w);
    is_trigger = w.strobe & w.data[`CTRL_TRIG_BIT];
  endfunction : is_trigger

endpackage : sar_adc_pkg

//--- sar_approx_register.sv
// Successive-approximation register: trial code towards the DAC and final result.
// Assumes comp_in is high while the analog input is at or above the trial level.
`timescale 1ns/10ps
`include "sar_adc_params.svh"

module sar_approx_register (
  input  wire logic                     clock_in,
  input  wire logic                     rst_in,
  input  wire logic                     start_in,
  input  wire logic                     abort_in,
  input  wire logic                     step_in,
  input  wire logic                     comp_in,
  output logic      [`RESULT_WIDTH-1:0] trial_code_out,
  output logic      [`RESULT_WIDTH-1:0] result_out,
  output logic                          finish_out
);
  import sar_adc_pkg::*;

  logic [`RESULT_WIDTH-1:0] trial_r, trial_nxt;
  logic [`RESULT_WIDTH-1:0] mask_r, mask_nxt;
  logic [`RESULT_WIDTH-1:0] result_r, result_nxt;
  logic                     finish_r, finish_nxt;
  logic [`RESULT_WIDTH-1:0] decided;

  always_comb begin
    trial_nxt  = trial_r;
    mask_nxt   = mask_r;
    result_nxt = result_r;
    finish_nxt = 1'b0;
    decided    = comp_in ? trial_r : (trial_r & ~mask_r);
    if (start_in) begin
      trial_nxt = `SAR_FIRST_MASK;
      mask_nxt  = `SAR_FIRST_MASK;
    end else if (abort_in) begin
      mask_nxt = '0;
    end else if (step_in && (mask_r != '0)) begin
      // Each bit is kept only if the input reaches its level, so 256 equal steps result.
      trial_nxt = decided | (mask_r >> 1);
      mask_nxt  = mask_r >> 1;
      if (mask_r == `SAR_LAST_MASK) begin
        // All-high comparisons give full scale, all-low give zero, with no overflow.
        result_nxt = decided;
        finish_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      trial_r  <= '0;
      mask_r   <= '0;
      result_r <= `RESULT_RESET;
      finish_r <= 1'b0;
    end else begin
      trial_r  <= trial_nxt;
      mask_r   <= mask_nxt;
      result_r <= result_nxt;
      finish_r <= finish_nxt;
    end
  end

  assign trial_code_out = trial_r;
  assign result_out     = result_r;
  assign finish_out     = finish_r;

  property p_bit_decided;
    @(posedge clock_in) disable iff (rst_in)
      (step_in && !start_in && !abort_in && (mask_r != '0) && !comp_in)
      |=> ((trial_r & $past(mask_r)) == '0);
  endproperty
  a_bit_decided: assert property (p_bit_decided) else $error("rejected bit kept");

  property p_full_scale;
    @(posedge clock_in) disable iff (rst_in)
      (step_in && !start_in && !abort_in && mask_r == `SAR_LAST_MASK && comp_in
       && trial_r == {`RESULT_WIDTH{1'b1}})
      |=> (result_r == {`RESULT_WIDTH{1'b1}}) && finish_r;
  endproperty
  a_full_scale: assert property (p_full_scale) else $error("full scale lost");

endmodule : sar_approx_register

//--- sar_adc_conversion_control.sv
// Conversion control of the 8-bit successive-approximation converter.
// Assumes register accesses arrive as one-cycle write strobes and the comparator is synchronous.
`timescale 1ns/10ps
`include "sar_adc_params.svh"

// Notes on behaviour
// - Successive approximation yields an 8-bit unsigned result.
// - Input at upper reference gives all ones.
// - Input at lower reference gives zero.
// - Results are monotonic with the input.
// - Span is split into 256 equal steps.
// - Trigger write starts conversion and clears done.
// - Hardware sets done when a conversion ends.
// - Interrupt at completion only when enabled.
// - Trigger during conversion restarts a fresh one.
// - Trigger bit always reads as zero.
// - One conversion per trigger, never repeated.
// - Done clears only on start, not writes; the code also clears it on a trigger write while powered off.
// - Conversion takes about 70 microseconds.
// - Keeps running in WAIT; interrupt wakes it.
// - Power off switches the converter off.
// - Power bit one means on.
// - Control reads 40h after reset.
module sar_adc_conversion_control #(
  parameter int unsigned BIT_CYCLES = `BIT_CYCLES
) (
  input  wire logic                     clock_in,
  input  wire logic                     rst_in,
  input  wire sar_adc_pkg::ctrl_write_t ctrl_wr_in,
  input  wire logic                     wait_mode_in,
  input  wire logic                     stop_mode_in,
  input  wire logic                     comp_in,
  output logic      [`CTRL_WIDTH-1:0]   ctrl_rdata_out,
  output logic      [`RESULT_WIDTH-1:0] result_out,
  output logic      [`RESULT_WIDTH-1:0] dac_code_out,
  output logic                          analog_power_out,
  output logic                          busy_out,
  output logic                          irq_out,
  output logic                          wake_out
);
  import sar_adc_pkg::*;

  localparam int unsigned DIV_W = $clog2(BIT_CYCLES + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BIT_CYCLES - 1);

  conv_state_t      state_r, state_nxt;
  ctrl_bits_t       ctrl_r, ctrl_nxt;
  logic             done_r, done_nxt;
  logic [DIV_W-1:0] div_r, div_nxt;
  logic             trig;
  logic             active;
  logic             start;
  logic             abort;
  logic             step;
  logic             finish;

  assign trig   = is_trigger(ctrl_wr_in);
  // Power one means on; STOP forces the converter off whatever software set.
  assign active = ctrl_r.power_on & ~stop_mode_in;
  // The trigger is sampled in every cycle, so a write mid-conversion restarts it.
  assign start  = trig & active;
  assign abort  = (state_r == ST_CONVERT) & ~active;
  assign step   = (state_r == ST_CONVERT) & active & ~trig & (div_r == DIV_LAST);

  always_comb begin
    ctrl_nxt  = ctrl_r;
    done_nxt  = done_r;
    state_nxt = state_r;
    div_nxt   = div_r;
    if (ctrl_wr_in.strobe) begin
      ctrl_nxt.irq_en   = ctrl_wr_in.data[`CTRL_IRQ_EN_BIT];
      ctrl_nxt.power_on = ctrl_wr_in.data[`CTRL_POWER_BIT];
    end
    // The done bit of a write is ignored; only a trigger clears it.
    if (trig) begin
      done_nxt = 1'b0;
    end
    // A completion in the same cycle as a trigger still sets the flag.
    if (finish) begin
      done_nxt = 1'b1;
    end
    unique case (state_r)
      ST_IDLE: begin
        // Nothing restarts here without a fresh trigger.
        if (start) begin
          state_nxt = ST_CONVERT;
          div_nxt   = '0;
        end
      end
      ST_CONVERT: begin
        if (!active) begin
          state_nxt = ST_IDLE;
        end else if (trig) begin
          div_nxt = '0;
        end else if (finish) begin
          state_nxt = ST_IDLE;
        end else begin
          // Eight bit periods make up the conversion time.
          div_nxt = step ? '0 : div_r + DIV_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_r <= ST_IDLE;
      ctrl_r  <= '0;
      done_r  <= 1'b1;
      div_r   <= '0;
    end else begin
      state_r <= state_nxt;
      ctrl_r  <= ctrl_nxt;
      done_r  <= done_nxt;
      div_r   <= div_nxt;
    end
  end

  sar_approx_register u_sar (
    .clock_in       (clock_in),
    .rst_in         (rst_in),
    .start_in       (start),
    .abort_in       (abort),
    .step_in        (step),
    .comp_in        (comp_in),
    .trial_code_out (dac_code_out),
    .result_out     (result_out),
    .finish_out     (finish)
  );

  // The trigger position is never stored, so a read of it can only give zero.
  assign ctrl_rdata_out   = {ctrl_r.irq_en, done_r, 1'b0, ctrl_r.power_on, 4'h0};
  assign analog_power_out = active;
  assign busy_out         = (state_r == ST_CONVERT);
  // The request is a level that stays while the flag stays, so the handler must mask it.
  assign irq_out          = done_r & ctrl_r.irq_en;
  // WAIT leaves the converter running; STOP has no wake path from here.
  assign wake_out         = irq_out & wait_mode_in & ~stop_mode_in;

  logic [15:0] conv_cnt_r, conv_cnt_nxt;

  always_comb begin
    conv_cnt_nxt = conv_cnt_r + 16'h0001;
    if (start || state_r != ST_CONVERT) begin
      conv_cnt_nxt = '0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      conv_cnt_r <= '0;
    end else begin
      conv_cnt_r <= conv_cnt_nxt;
    end
  end

  sequence s_trigger;
    trig && active;
  endsequence

  sequence s_restarted;
    (state_r == ST_CONVERT) && (div_r == '0) && (dac_code_out == `SAR_FIRST_MASK);
  endsequence

  property p_start_clears_done;
    @(posedge clock_in) disable iff (rst_in)
      trig && !finish |=> !done_r;
  endproperty
  a_start_clears_done: assert property (p_start_clears_done) else $error("done not cleared");

  property p_finish_sets_done;
    @(posedge clock_in) disable iff (rst_in)
      finish |=> done_r && (state_r == ST_IDLE || $past(trig));
  endproperty
  a_finish_sets_done: assert property (p_finish_sets_done) else $error("done not set");

  // A completion with the enable set and no control write in that cycle must raise the request in the very next cycle.
  property p_irq_on_done;
    @(posedge clock_in) disable iff (rst_in)
      finish && ctrl_r.irq_en && !ctrl_wr_in.strobe |=> irq_out;
  endproperty
  a_irq_on_done: assert property (p_irq_on_done) else $error("irq wrong at done");

  property p_restart;
    @(posedge clock_in) disable iff (rst_in)
      s_trigger |=> s_restarted;
  endproperty
  a_restart: assert property (p_restart) else $error("trigger did not restart");

  property p_trig_reads_zero;
    @(posedge clock_in) disable iff (rst_in)
      ctrl_rdata_out[`CTRL_TRIG_BIT] == 1'b0;
  endproperty
  a_trig_reads_zero: assert property (p_trig_reads_zero) else $error("trigger bit read high");

  property p_no_repeat;
    @(posedge clock_in) disable iff (rst_in)
      (state_r == ST_IDLE) && !trig |=> (state_r == ST_IDLE);
  endproperty
  a_no_repeat: assert property (p_no_repeat) else $error("conversion began unasked");

  property p_done_sticky;
    @(posedge clock_in) disable iff (rst_in)
      done_r && !trig |=> done_r;
  endproperty
  a_done_sticky: assert property (p_done_sticky) else $error("done cleared without start");

  property p_conv_time;
    @(posedge clock_in) disable iff (rst_in)
      conv_cnt_r <= 16'(BIT_CYCLES * `RESULT_WIDTH + 2);
  endproperty
  a_conv_time: assert property (p_conv_time) else $error("conversion overran");

  property p_wake;
    @(posedge clock_in) disable iff (rst_in)
      wait_mode_in && !stop_mode_in && done_r && ctrl_r.irq_en |-> wake_out;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake from wait");

  property p_power_off;
    @(posedge clock_in) disable iff (rst_in)
      !active |=> (state_r == ST_IDLE) && !$past(step);
  endproperty
  a_power_off: assert property (p_power_off) else $error("converter ran unpowered");

  property p_stop;
    @(posedge clock_in) disable iff (rst_in)
      stop_mode_in |-> !wake_out && !analog_power_out;
  endproperty
  a_stop: assert property (p_stop) else $error("active in stop");

  property p_reset_value;
    @(posedge clock_in)
      $past(rst_in) && !rst_in |-> (ctrl_rdata_out == `CTRL_RESET);
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("bad control reset value");

endmodule : sar_adc_conversion_control

//--- analog_source_model.sv
// Analog source on the one selected input pin, with the comparator that it feeds.
// Assumes levels in code steps; a level above FFh stands for an input past the top reference.
`timescale 1ns/10ps

module analog_source_model (
  input  wire logic [8:0] level_in,
  input  wire logic [7:0] dac_code_in,
  input  wire logic       power_in,
  output logic            comp_out
);
  // Only one source ever drives the converter input, so no two pins are shorted.
  // An unpowered comparator makes no decision and reads low.
  assign comp_out = power_in & (level_in >= {1'b0, dac_code_in});
endmodule : analog_source_model

//--- sar_adc_conversion_control_bench.sv
// Self-checking bench of the converter control block with an analog source model.
// Assumes the package and constants header are compiled first; BIT_CYCLES is shortened.
`timescale 1ns/10ps

module sar_adc_conversion_control_bench;
  import sar_adc_pkg::*;
  localparam int BITS = 2;
  localparam int CONV = 8 * BITS + 2;
  logic        clock_in, rst_in, wait_mode, stop_mode, comp, power, busy, irq, wake;
  ctrl_write_t wr;
  logic [7:0]  rdata, result, dac;
  logic [8:0]  level;
  int          err_total, compares;

  sar_adc_conversion_control #(.BIT_CYCLES(BITS)) sar_adc_conversion_control_i (
    .clock_in(clock_in), .rst_in(rst_in), .ctrl_wr_in(wr), .wait_mode_in(wait_mode),
    .stop_mode_in(stop_mode), .comp_in(comp), .ctrl_rdata_out(rdata), .result_out(result),
    .dac_code_out(dac), .analog_power_out(power), .busy_out(busy), .irq_out(irq),
    .wake_out(wake));
  analog_source_model analog_source_model_i (
    .level_in(level), .dac_code_in(dac), .power_in(power), .comp_out(comp));

  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk1

  task automatic cycles(input int k);
    repeat (k) @(posedge clock_in);
    #1;
  endtask : cycles

  // The strobe is lowered at the edge that samples it, so each write is taken once.
  task automatic write_ctrl(input logic [7:0] d);
    @(posedge clock_in);
    wr <= '{strobe: 1'b1, data: d};
    @(posedge clock_in);
    wr <= '{strobe: 1'b0, data: 8'h00};
    #1;
  endtask : write_ctrl

  task automatic wait_done(output int n);
    n = 0;
    while (rdata[6] !== 1'b1) begin
      if (n == 200) begin
        err_total++;
        finish_test();
      end
      cycles(1);
      n++;
    end
  endtask : wait_done

  task automatic convert(input logic [8:0] lvl, input logic [7:0] exp, input logic [7:0] ctl);
    int n;
    level = lvl;
    write_ctrl(ctl | 8'h20);
    chk1(busy, 1'b1);
    chk1(rdata[6], 1'b0);
    chk8(rdata & 8'h20, 8'h00);
    chk8(dac, 8'h80);
    wait_done(n);
    chk1(n >= CONV - 1 && n <= CONV + 1, 1'b1);
    chk8(result, exp);
    chk1(busy, 1'b0);
  endtask : convert

  task automatic t_reset_power();
    chk8(rdata, 8'h40);
    chk8(result, 8'h00);
    chk1(irq, 1'b0);
    write_ctrl(8'h10);
    chk8(rdata, 8'h50);
    chk1(power, 1'b1);
  endtask : t_reset_power

  task automatic t_codes();
    logic [8:0] lv [7] = '{9'h000, 9'h001, 9'h07F, 9'h080, 9'h0AA, 9'h0FF, 9'h12C};
    logic [7:0] prev;
    prev = 8'h00;
    foreach (lv[i]) begin
      convert(lv[i], (lv[i] > 9'h0FF) ? 8'hFF : lv[i][7:0], 8'h10);
      chk1(result >= prev, 1'b1);
      prev = result;
    end
  endtask : t_codes

  task automatic t_hold_restart();
    int n;
    level = 9'h033;
    cycles(30);
    chk1(busy, 1'b0);
    chk8(result, 8'hFF);
    write_ctrl(8'h10);
    chk1(rdata[6], 1'b1);
    level = 9'h040;
    write_ctrl(8'h30);
    cycles(5);
    level = 9'h0C0;
    write_ctrl(8'h30);
    chk8(dac, 8'h80);
    wait_done(n);
    chk8(result, 8'hC0);
  endtask : t_hold_restart

  task automatic t_irq();
    convert(9'h055, 8'h55, 8'h10);
    chk1(irq, 1'b0);
    write_ctrl(8'h90);
    chk1(irq, 1'b1);
    write_ctrl(8'h10);
    @(posedge clock_in);
    wait_mode <= 1'b1;
    convert(9'h0E1, 8'hE1, 8'h90);
    chk1(irq, 1'b1);
    chk1(wake, 1'b1);
    @(posedge clock_in);
    stop_mode <= 1'b1;
    cycles(1);
    chk1(wake, 1'b0);
    chk1(power, 1'b0);
    @(posedge clock_in);
    stop_mode <= 1'b0;
    wait_mode <= 1'b0;
    write_ctrl(8'h10);
    chk1(irq, 1'b0);
  endtask : t_irq

  // Both kinds of abort leave done low, since no completion ever occurs.
  task automatic t_abort();
    write_ctrl(8'h30);
    cycles(4);
    write_ctrl(8'h00);
    chk1(power, 1'b0);
    cycles(40);
    chk1(busy, 1'b0);
    chk1(rdata[6], 1'b0);
    write_ctrl(8'h30);
    chk1(busy, 1'b0);
    write_ctrl(8'h10);
    write_ctrl(8'h30);
    @(posedge clock_in);
    stop_mode <= 1'b1;
    cycles(40);
    chk1(busy, 1'b0);
    chk1(rdata[6], 1'b0);
  endtask : t_abort

  initial begin
    rst_in = 1'b1;
    wr = '0;
    wait_mode = 1'b0;
    stop_mode = 1'b0;
    level = 9'h000;
    err_total = 0;
    compares = 0;
    repeat (5) @(posedge clock_in);
    rst_in <= 1'b0;
    #1;
    t_reset_power();
    t_codes();
    t_hold_restart();
    t_irq();
    t_abort();
    finish_test();
  end
endmodule : sar_adc_conversion_control_bench
